/* File: shared/urx_pkg.sv */
// urx_pkg: constants, field positions, states and helpers of the receiver
// assumes: one crystal-rate clock; mode words arrive as plain ports
package urx_pkg;

   // ---------------------------------------------------------------
   // sizes
   // ---------------------------------------------------------------
   localparam int unsigned DATA_W = 8;
   localparam int unsigned QUEUE_DEPTH = 8;
   localparam int unsigned ENT_W = 11;
   localparam logic [3:0] TX_QUEUE_SLOTS = 4'h8;

   // ---------------------------------------------------------------
   // queue entry layout: data, then three status bits
   // ---------------------------------------------------------------
   localparam int unsigned ENT_PE = 8;
   localparam int unsigned ENT_FE = 9;
   localparam int unsigned ENT_BRK = 10;

   // ---------------------------------------------------------------
   // mode word fields
   // ---------------------------------------------------------------
   localparam int unsigned MRF_WDOG_EN = 7;
   localparam int unsigned MRS_ERR_MODE = 5;
   localparam int unsigned MRS_PAR_HI = 4;
   localparam int unsigned MRS_PAR_LO = 3;
   localparam int unsigned MRS_PAR_TYPE = 2;
   localparam int unsigned MRS_LEN_HI = 1;
   localparam int unsigned MRS_LEN_LO = 0;
   localparam logic [1:0] PAR_WITH = 2'h0;
   localparam logic [1:0] PAR_FORCE = 2'h1;
   localparam logic [1:0] PAR_NONE = 2'h2;
   localparam logic [1:0] PAR_MULTIDROP = 2'h3;

   // ---------------------------------------------------------------
   // timing counts and reset values
   // ---------------------------------------------------------------
   localparam logic [3:0] DIV_SAMPLE = 4'h7;
   localparam logic [3:0] DIV_LAST = 4'hF;
   localparam logic [3:0] HALF_BIT_LAST = 4'h7;
   localparam logic [3:0] MIN_DATA_BITS = 4'h5;
   localparam logic [1:0] LOAD_DELAY_PLAIN = 2'h1;
   localparam logic [1:0] LOAD_DELAY_HALVED = 2'h2;
   localparam logic [1:0] BREAK_END_EDGES = 2'h2;
   localparam logic [6:0] WDOG_BIT_TIMES = 7'h40;
   localparam logic [2:0] FILL_CODE_MAX = 3'h7;
   localparam logic RESET_LINE = 1'b1;

   // ---------------------------------------------------------------
   // receiver states
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      URX_IDLE = 3'b000,
      URX_START_CHK = 3'b001,
      URX_DATA = 3'b010,
      URX_FE_WAIT = 3'b011,
      URX_BREAK_WAIT = 3'b100
   } urx_state_e;

   // fill or free count to a 3-bit code, eight saturating at seven
   function automatic logic [2:0] sat_code(input logic [3:0] n);
      sat_code = (n >= 4'h7) ? FILL_CODE_MAX : n[2:0];
   endfunction

endpackage

/* File: verilog/urx_queue.sv */
// urx_queue: flip-flop first-in-first-out store for received entries
// assumes: the writer never pushes while full
`timescale 1ns/1ps
module urx_queue #(
   parameter int unsigned WIDTH = 11,
   parameter int unsigned DEPTH = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic push,
   input wire logic pop,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] head,
   output logic [$clog2(DEPTH):0] count,
   output logic full,
   output logic empty
);
   localparam int unsigned AW = $clog2(DEPTH);

   if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("urx_queue depth must be a power of two");
   end

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic do_push;
   logic do_pop;

   // guarded strobes
   assign do_push = push && !full;
   assign do_pop = pop && !empty;
   assign full = (count == (AW+1)'(DEPTH));
   assign empty = (count == '0);
   assign head = mem[rd_ptr];

   // storage
   always_ff @(posedge clk) begin
      if (do_push) begin
         mem[wr_ptr] <= din;
      end
   end

   // pointers and occupancy
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (do_push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (do_pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
         if (do_push && !do_pop) begin
            count <= count + 1'b1;
         end else if (do_pop && !do_push) begin
            count <= count - 1'b1;
         end
      end
   end
endmodule // urx_queue

/* File: verilog/urx_receiver.sv */
// urx_receiver: serial receive path with queue, status, watchdog, wake-up
// assumes: clk is the crystal clock; line and bit-rate clock are async pins
`timescale 1ns/1ps
module urx_receiver #(
   parameter int unsigned QUEUE_DEPTH = urx_pkg::QUEUE_DEPTH
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic serial_in,
   input wire logic rx_bit_rate_clock,
   input wire logic rx_enable,
   input wire logic mode_16x,
   input wire logic clock_halve,
   input wire logic [7:0] mode_register_first,
   input wire logic [7:0] mode_register_second,
   input wire logic rx_read,
   input wire logic error_reset,
   input wire logic [3:0] tx_queue_level,
   input wire logic tx_idle_flag,
   output logic [7:0] rx_data,
   output logic rx_char_available,
   output logic rx_queue_full_flag,
   output logic [2:0] rx_fill_code,
   output logic parity_err,
   output logic framing_err,
   output logic break_stat,
   output logic overrun_err,
   output logic change_of_break,
   output logic watchdog_expired,
   output logic [2:0] tx_free_code,
   output logic tx_queue_empty_flag,
   output logic tx_addr_data
);
   localparam int unsigned CW = $clog2(QUEUE_DEPTH) + 1;

   if (QUEUE_DEPTH < 2 || QUEUE_DEPTH > 8
       || (QUEUE_DEPTH & (QUEUE_DEPTH - 1)) != 0) begin : g_bad_depth
      $error("urx_receiver queue depth must be 2, 4 or 8");
   end

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   logic [1:0] line_sync;
   logic [1:0] bclk_sync;
   logic bclk_prev;
   logic line;
   logic tick;

   // two flops per pin, third flop only for bit clock edge detection
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_sync <= {2{urx_pkg::RESET_LINE}};
         bclk_sync <= 2'h0;
         bclk_prev <= 1'b0;
      end else begin
         line_sync <= {line_sync[0], serial_in};
         bclk_sync <= {bclk_sync[0], rx_bit_rate_clock};
         bclk_prev <= bclk_sync[1];
      end
   end
   assign line = line_sync[1];
   assign tick = bclk_sync[1] && !bclk_prev;

   // ---------------------------------------------------------------
   // mode decode
   // ---------------------------------------------------------------
   logic [1:0] par_mode;
   logic par_type;
   logic multidrop;
   logic active;
   logic par_used;
   logic [3:0] data_bits;
   logic [3:0] last_idx;
   logic [7:0] len_mask;

   assign par_mode = mode_register_second[urx_pkg::MRS_PAR_HI:
                                          urx_pkg::MRS_PAR_LO];
   assign par_type = mode_register_second[urx_pkg::MRS_PAR_TYPE];
   assign multidrop = (par_mode == urx_pkg::PAR_MULTIDROP);
   assign active = rx_enable || multidrop;
   assign par_used = (par_mode != urx_pkg::PAR_NONE);
   assign data_bits = urx_pkg::MIN_DATA_BITS
                    + {2'h0, mode_register_second[urx_pkg::MRS_LEN_HI:
                                                  urx_pkg::MRS_LEN_LO]};
   assign last_idx = data_bits + {3'h0, par_used};
   assign len_mask = 8'hFF >> (4'h8 - data_bits);

   // ---------------------------------------------------------------
   // receiver state machine
   // ---------------------------------------------------------------
   urx_pkg::urx_state_e state;
   logic [3:0] div;
   logic [3:0] bit_idx;
   logic [9:0] shreg;
   logic line_prev;
   logic [1:0] high_cnt;
   logic fall;
   logic samp;
   logic start_ok;
   logic char_done;
   logic break_end;

   assign fall = line_prev && !line;
   assign samp = mode_16x ? (tick && div == urx_pkg::DIV_SAMPLE) : tick;
   assign start_ok = mode_16x
                   ? (state == urx_pkg::URX_START_CHK && samp && !line)
                   : (state == urx_pkg::URX_IDLE && active && tick && !line);
   assign char_done = (state == urx_pkg::URX_DATA) && samp
                   && (bit_idx == last_idx);
   assign break_end = (state == urx_pkg::URX_BREAK_WAIT) && line
                   && (high_cnt == urx_pkg::BREAK_END_EDGES - 2'h1);

   // character fields taken at the stop sample
   logic [7:0] rx_word;
   logic pbit;
   logic fe;
   logic brk;
   logic pe_slot;
   logic keep;

   always_comb begin
      rx_word = shreg[7:0] & len_mask;
      pbit = par_used ? shreg[data_bits] : 1'b0;
      fe = !line;
      brk = fe && (rx_word == 8'h00) && !pbit;
      unique case (par_mode)
         urx_pkg::PAR_WITH: pe_slot = ((^rx_word) ^ pbit) != par_type;
         urx_pkg::PAR_FORCE: pe_slot = (pbit != par_type);
         urx_pkg::PAR_NONE: pe_slot = 1'b0;
         urx_pkg::PAR_MULTIDROP: pe_slot = pbit;
      endcase
      keep = !multidrop || rx_enable || pbit || brk;
   end

   // edge tracker; held high while disabled or not idle so a low line at enable is an edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         line_prev <= urx_pkg::RESET_LINE;
      end else if (!active || state != urx_pkg::URX_IDLE) begin
         line_prev <= urx_pkg::RESET_LINE;
      end else begin
         line_prev <= line;
      end
   end

   // sequencing, divider and shift register
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= urx_pkg::URX_IDLE;
         div <= 4'h0;
         bit_idx <= 4'h0;
         shreg <= 10'h000;
         high_cnt <= 2'h0;
      end else if (!active && state != urx_pkg::URX_BREAK_WAIT) begin
         state <= urx_pkg::URX_IDLE;
      end else begin
         if (tick) begin
            div <= div + 4'h1;
         end
         unique case (state)
            urx_pkg::URX_IDLE: begin
               bit_idx <= 4'h0;
               if (mode_16x && fall) begin
                  div <= 4'h0;
                  state <= urx_pkg::URX_START_CHK;
               end else if (start_ok) begin
                  state <= urx_pkg::URX_DATA;
               end
            end
            urx_pkg::URX_START_CHK: begin
               if (samp) begin
                  state <= line ? urx_pkg::URX_IDLE
                                : urx_pkg::URX_DATA;
               end
            end
            urx_pkg::URX_DATA: begin
               if (samp) begin
                  shreg[bit_idx] <= line;
                  bit_idx <= bit_idx + 4'h1;
               end
               if (char_done) begin
                  high_cnt <= 2'h0;
                  div <= 4'h0;
                  if (brk) begin
                     state <= urx_pkg::URX_BREAK_WAIT;
                  end else if (fe && mode_16x) begin
                     state <= urx_pkg::URX_FE_WAIT;
                  end else begin
                     state <= urx_pkg::URX_IDLE;
                  end
               end
            end
            urx_pkg::URX_FE_WAIT: begin
               if (tick && div == urx_pkg::HALF_BIT_LAST) begin
                  bit_idx <= 4'h0;
                  div <= 4'h0;
                  state <= line ? urx_pkg::URX_IDLE
                                : urx_pkg::URX_START_CHK;
               end
            end
            urx_pkg::URX_BREAK_WAIT: begin
               high_cnt <= line ? high_cnt + 2'h1 : 2'h0;
               if (break_end) begin
                  state <= urx_pkg::URX_IDLE;
               end
            end
            default: state <= urx_pkg::URX_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // shift-register hold stage and queue
   // ---------------------------------------------------------------
   logic [urx_pkg::ENT_W-1:0] hold_word;
   logic hold_valid;
   logic [1:0] load_cnt;
   logic push;
   logic pop;
   logic [urx_pkg::ENT_W-1:0] head;
   logic [CW-1:0] q_count;
   logic q_full;
   logic q_empty;

   assign push = hold_valid && (load_cnt == 2'h0) && !q_full;
   assign pop = rx_read && !q_empty;

   // held character; a new one overwrites a stalled one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         hold_word <= '0;
         hold_valid <= 1'b0;
         load_cnt <= 2'h0;
      end else if (char_done && keep) begin
         hold_word <= {brk, fe, pe_slot, rx_word};
         hold_valid <= 1'b1;
         load_cnt <= clock_halve ? urx_pkg::LOAD_DELAY_HALVED - 2'h1
                                 : urx_pkg::LOAD_DELAY_PLAIN - 2'h1;
      end else if (push) begin
         hold_valid <= 1'b0;
      end else if (hold_valid && load_cnt != 2'h0) begin
         load_cnt <= load_cnt - 2'h1;
      end
   end

   urx_queue #(
      .WIDTH(urx_pkg::ENT_W),
      .DEPTH(QUEUE_DEPTH)
   ) u_queue (
      .clk(clk),
      .reset_n(reset_n),
      .push(push),
      .pop(pop),
      .din(hold_word),
      .head(head),
      .count(q_count),
      .full(q_full),
      .empty(q_empty)
   );

   // ---------------------------------------------------------------
   // status
   // ---------------------------------------------------------------
   logic [2:0] err_acc;
   logic [2:0] next_err_acc;
   logic [2:0] head_err;

   assign head_err = q_empty ? 3'h0 : head[urx_pkg::ENT_BRK:urx_pkg::ENT_PE];
   assign next_err_acc = (error_reset ? 3'h0 : err_acc) | head_err;

   // block-mode accumulator, the head's bits win over a reset
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         err_acc <= 3'h0;
      end else begin
         err_acc <= next_err_acc;
      end
   end

   // visible status, all updated on the same edge
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rx_data <= 8'h00;
         rx_char_available <= 1'b0;
         rx_queue_full_flag <= 1'b0;
         rx_fill_code <= 3'h0;
         {break_stat, framing_err, parity_err} <= 3'h0;
      end else begin
         rx_data <= q_empty ? 8'h00 : head[7:0];
         rx_char_available <= !q_empty;
         rx_queue_full_flag <= q_full;
         rx_fill_code <= urx_pkg::sat_code(4'(q_count));
         if (mode_register_second[urx_pkg::MRS_ERR_MODE]) begin
            {break_stat, framing_err, parity_err} <= next_err_acc;
         end else begin
            {break_stat, framing_err, parity_err} <= head_err;
         end
      end
   end

   // overrun: set at the start of a character that meets a stalled one
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         overrun_err <= 1'b0;
      end else if (start_ok && hold_valid && q_full) begin
         overrun_err <= 1'b1;
      end else if (error_reset) begin
         overrun_err <= 1'b0;
      end
   end

   // change-of-break pulse on break entry and break end
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         change_of_break <= 1'b0;
      end else begin
         change_of_break <= (char_done && brk) || break_end;
      end
   end

   // ---------------------------------------------------------------
   // watchdog
   // ---------------------------------------------------------------
   logic [3:0] presc;
   logic bit_tick;
   logic [6:0] wd_cnt;

   assign bit_tick = mode_16x ? (tick && presc == urx_pkg::DIV_LAST) : tick;

   // bit-time counter restarted by queue traffic
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         presc <= 4'h0;
         wd_cnt <= 7'h00;
         watchdog_expired <= 1'b0;
      end else begin
         if (tick) begin
            presc <= presc + 4'h1;
         end
         if (push || pop) begin
            wd_cnt <= 7'h00;
         end else if (bit_tick && wd_cnt != urx_pkg::WDOG_BIT_TIMES) begin
            wd_cnt <= wd_cnt + 7'h01;
         end
         watchdog_expired <= mode_register_first[urx_pkg::MRF_WDOG_EN]
                          && (wd_cnt == urx_pkg::WDOG_BIT_TIMES);
      end
   end

   // ---------------------------------------------------------------
   // transmit-side indications
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tx_free_code <= urx_pkg::FILL_CODE_MAX;
         tx_queue_empty_flag <= 1'b1;
         tx_addr_data <= 1'b0;
      end else begin
         tx_free_code <= urx_pkg::sat_code(urx_pkg::TX_QUEUE_SLOTS
                                           - tx_queue_level);
         tx_queue_empty_flag <= (tx_queue_level == 4'h0);
         if (tx_idle_flag) begin
            tx_addr_data <= par_type;
         end
      end
   end

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_two_high;
      (state == urx_pkg::URX_BREAK_WAIT && line && high_cnt == 2'h0)
      ##1 (state == urx_pkg::URX_BREAK_WAIT && line);
   endsequence

   a_tx_free_code:
   assert property (@(posedge clk) disable iff (!reset_n)
      tx_queue_level == 4'h0 |=> tx_free_code == 3'h7 && tx_queue_empty_flag)
      else $error("tx free code wrong when empty");

   a_edge_zero_div:
   assert property (@(posedge clk) disable iff (!reset_n)
      state == urx_pkg::URX_IDLE && active && mode_16x && fall
      |=> state == urx_pkg::URX_START_CHK && div == 4'h0)
      else $error("falling edge did not zero divider");

   a_false_start:
   assert property (@(posedge clk) disable iff (!reset_n)
      state == urx_pkg::URX_START_CHK && active && samp && line
      |=> state == urx_pkg::URX_IDLE)
      else $error("high at count 7 did not discard start");

   a_onex_no_check:
   assert property (@(posedge clk) disable iff (!reset_n)
      !mode_16x && active && state == urx_pkg::URX_IDLE && tick && !line
      |=> state == urx_pkg::URX_DATA)
      else $error("1x start not taken directly");

   a_load_delay:
   assert property (@(posedge clk) disable iff (!reset_n)
      $rose(hold_valid) && !q_full |-> ##[0:1] push)
      else $error("character not loaded in time");

   a_short_zero:
   assert property (@(posedge clk) disable iff (!reset_n)
      push && data_bits == 4'h5 |-> hold_word[7:5] == 3'h0)
      else $error("upper bits of short character not zero");

   a_break_zero:
   assert property (@(posedge clk) disable iff (!reset_n)
      push && hold_word[urx_pkg::ENT_BRK] |-> hold_word[7:0] == 8'h00)
      else $error("break character not zero");

   a_break_end:
   assert property (@(posedge clk) disable iff (!reset_n)
      s_two_high |=> state == urx_pkg::URX_IDLE && change_of_break)
      else $error("break end not seen after two high edges");

   a_fill_full:
   assert property (@(posedge clk) disable iff (!reset_n)
      q_full |=> rx_fill_code == 3'h7 && rx_queue_full_flag)
      else $error("full queue not coded as 7");

   a_pop_read:
   assert property (@(posedge clk) disable iff (!reset_n)
      rx_read && !q_empty && !push |=> q_count == $past(q_count) - 1'b1)
      else $error("read did not pop one entry");
endmodule // urx_receiver

/* File: tb/urx_line_model.sv */
// urx_line_model: remote transmitter driving the receive line
// assumes: tick is the free running 16x or 1x bit-rate clock
`timescale 1ns/1ps
module urx_line_model (
   input wire logic tick,
   output logic line
);
   // ---------------------------------------------------------------
   // frame sender: bit 0 first, k ticks a bit, idle high after
   // ---------------------------------------------------------------
   initial line = 1'b1;
   // in 1x the line moves mid-period so the rising edge sits mid-cell
   task automatic send(input logic [10:0] f, input int n, input int k);
      for (int i = 0; i < n; i++) begin
         repeat (k) @(posedge tick);
         #((k == 1) ? 50 : 1) line = f[i];
      end
      repeat (k) @(posedge tick);
      #((k == 1) ? 50 : 1) line = 1'b1;
   endtask
endmodule // urx_line_model

/* File: tb/testbench.sv */
// testbench: self-checking run of the receiver against a line model
// assumes: 16x bit clock of 100 ns, mode words as plain ports
`timescale 1ns/1ps
module testbench;
   logic clk, reset_n, tick, ser, rx_en, rd, err_rst, tx_idle, m16, halve;
   logic [7:0] mr0, mr1, data;
   logic [3:0] tx_lvl;
   logic avail, full, pe, fe, brk, ovr, cob, wdog, txe, txad;
   logic [2:0] fill, free;
   int error_cnt, checks_done, cob_cnt;
   urx_line_model i_tx (.tick(tick), .line(ser));
   urx_receiver i_dut (.clk(clk), .reset_n(reset_n), .serial_in(ser),
      .rx_bit_rate_clock(tick), .rx_enable(rx_en), .mode_16x(m16),
      .clock_halve(halve), .mode_register_first(mr0),
      .mode_register_second(mr1), .rx_read(rd), .error_reset(err_rst),
      .tx_queue_level(tx_lvl), .tx_idle_flag(tx_idle), .rx_data(data),
      .rx_char_available(avail), .rx_queue_full_flag(full),
      .rx_fill_code(fill), .parity_err(pe), .framing_err(fe),
      .break_stat(brk), .overrun_err(ovr), .change_of_break(cob),
      .watchdog_expired(wdog), .tx_free_code(free),
      .tx_queue_empty_flag(txe), .tx_addr_data(txad));
   // clocks and a counter of break-change pulses
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      tick = 1'b0;
      #5; // bit clock edges kept off the crystal edges
      forever #50 tick = ~tick;
   end
   always @(posedge clk) if (cob === 1'b1) cob_cnt++;
   // ---------------------------------------------------------------
   // shared helpers
   // ---------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic clks(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask
   task automatic send(input logic [10:0] f, input int n);
      i_tx.send(f, n, m16 ? 16 : 1);
      clks(10);
   endtask
   task automatic pop;
      rd = 1'b1;
      clks(1);
      rd = 1'b0;
      clks(2);
   endtask
   task automatic clr;
      err_rst = 1'b1;
      clks(1);
      err_rst = 1'b0;
      clks(2);
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_tx_free;
      for (int l = 0; l <= 8; l++) begin
         tx_lvl = 4'(l);
         clks(2);
         chk(8'(free), (l == 0) ? 8'h07 : 8'(8 - l));
         chk(8'(txe), 8'(l == 0));
      end
      $display("test tx free done");
   endtask
   task automatic t_char;
      send({2'b11, 8'h41, 1'b0}, 10);
      chk(data, 8'h41);
      chk({avail, full, pe, fe, brk, fill}, 8'h81);
      clks(5300);
      chk(8'(wdog), 8'h01);
      pop;
      chk(8'({wdog, avail}), 8'h00);
      mr1 = 8'h10;
      send({5'h1F, 5'h15, 1'b0}, 7);
      chk(data, 8'h15);
      pop;
      mr1 = 8'h07;
      send({2'b11, 8'h01, 1'b0}, 11);
      chk(8'({pe, fe}), 8'h02);
      pop;
      $display("test char done");
   endtask
   task automatic t_fill;
      mr1 = 8'h13;
      for (int i = 0; i < 10; i++)
         send({2'b11, 8'(8'hA0 + i), 1'b0}, 10);
      chk({3'b000, full, ovr, fill}, 8'h1F);
      for (int i = 0; i < 9; i++) begin
         chk(data, (i < 8) ? 8'(8'hA0 + i) : 8'hA9);
         pop;
      end
      chk(8'(avail), 8'h00);
      $display("test fill done");
   endtask
   task automatic t_break;
      cob_cnt = 0;
      send(11'h000, 10);
      chk(8'({data, brk, avail}), 8'h03);
      chk(8'(cob_cnt), 8'h02);
      pop;
      $display("test break done");
   endtask
   task automatic t_wake;
      mr1 = 8'h1F;
      rx_en = 1'b0;
      send({2'b10, 8'h33, 1'b0}, 11);
      chk(8'(avail), 8'h00);
      send({2'b11, 8'h55, 1'b0}, 11);
      chk(data, 8'h55);
      chk(8'({pe, txad}), 8'h03);
      pop;
      rx_en = 1'b1;
      send({2'b10, 8'h66, 1'b0}, 11);
      chk(8'({avail, pe}), 8'h02);
      pop;
      $display("test wake done");
   endtask
   task automatic t_block;
      mr1 = 8'h33;
      clr;
      chk(8'({ovr, brk, fe, pe}), 8'h00);
      send(11'h002, 11);
      clks(800);
      chk(data, 8'h01);
      chk(8'({fill, avail, fe}), 8'h0B);
      pop;
      chk(data, 8'hFF);
      chk(8'(fe), 8'h01);
      clr;
      chk(8'(fe), 8'h00);
      pop;
      $display("test block done");
   endtask
   task automatic t_onex;
      mr1 = 8'h13;
      m16 = 1'b0;
      halve = 1'b1;
      send({2'b11, 8'h5A, 1'b0}, 10);
      chk(data, 8'h5A);
      pop;
      mr0 = 8'h00;
      clks(400);
      chk(8'(wdog), 8'h00);
      mr0 = 8'h80;
      clks(2);
      chk(8'(wdog), 8'h01);
      $display("test onex done");
   endtask
   // main sequence and watchdog
   initial begin
      reset_n = 1'b0;
      rx_en = 1'b1;
      m16 = 1'b1;
      halve = 1'b0;
      rd = 1'b0;
      err_rst = 1'b0;
      tx_idle = 1'b1;
      mr0 = 8'h80;
      mr1 = 8'h13;
      tx_lvl = 4'h0;
      clks(4);
      reset_n = 1'b1;
      clks(3);
      t_tx_free;
      t_char;
      t_fill;
      t_break;
      t_wake;
      t_block;
      t_onex;
      results;
   end
   initial begin
      #1_500_000;
      error_cnt++;
      results;
   end
endmodule // testbench
